// ### design/hbp_host_port.sv
// Host-facing target port: reset and boot strap capture, spike filter, fixed-address target, byte FIFOs
`timescale 1ns/1ps

// Functional notes
// - Held in reset while external reset low
// - Reset hold clears state, drive and FIFOs; release then runs
// - Attention low at release selects bootloader
// - One target at 0x55, repeated start
// - Fast-mode bus up to 400kbps
// - Spike filter on clock and data
// - Eight-byte receive FIFO
// - Eight-byte transmit FIFO
// - Bootloader accepts images over host link
module hbp_host_port #(
   parameter logic [6:0] TargetAddr = hbp_pkg::TARGET_ADDR,
   parameter int         Depth      = hbp_pkg::FIFO_DEPTH,
   parameter int         FiltLen    = hbp_pkg::FILT_LEN
) (
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire logic                 externalResetLow,      // Active low external reset
   input  wire logic                 motionIrqBootStrap,    // Strap sampled at release
   input  wire logic                 motionSelectBootStrap, // Strap sampled at release
   input  wire logic                 hostAttentionLine,     // Attention from host, low asserts
   input  wire hbp_pkg::hbp_pins_type pins,                 // Bus line levels
   output logic                      sdaOe,                 // High while pulling data low
   output logic                      sdaOut,                // Always low when enabled
   output logic                      sclOe,                 // Clock never stretched
   output logic                      sclOut,
   output logic                      coreRun,               // Device out of reset
   output logic                      bootMode,              // Bootloader selected
   output logic                      strapFault,            // Straps both low at release
   output logic                      hostWantsTalk,         // Attention held low
   output hbp_pkg::hbp_byte_type     rxByte,                // Received byte to core
   input  wire logic                 rxReady,               // Core takes rx byte
   input  wire hbp_pkg::hbp_byte_type txByte,               // Byte from core for host
   output logic                      txReady                // Tx FIFO has room
);
   // ----------------------------------------
   // State record
   // ----------------------------------------
   typedef struct packed {
      logic                   inRst;        // Holding reset
      logic                   boot;
      logic                   fault;
      logic [FiltLen-1:0]     sclSh;        // Filter history
      logic [FiltLen-1:0]     sdaSh;
      logic                   sclF;         // Filtered levels
      logic                   sdaF;
      hbp_pkg::hbp_state_type st;
      logic [3:0]             bitCnt;
      logic [7:0]             shift;
      logic                   rd;           // Read transfer
      logic                   drvLow;       // Pulling data low
      logic [Depth-1:0][7:0]  rxMem;        // Receive FIFO storage
      logic [2:0]             rxWp, rxRp;
      logic [3:0]             rxCnt;
      logic [Depth-1:0][7:0]  txMem;        // Transmit FIFO storage
      logic [2:0]             txWp, txRp;
      logic [3:0]             txCnt;
      logic                   nack;         // Refuse current byte
   } hbp_regs_type;

   hbp_regs_type r_reg, r_next;

   // Filtered edges, derived from registered levels
   logic sclRise, sclFall, startCond, stopCond;
   logic sclNew, sdaNew;
   logic rxPush, rxPop, txPush, txPop;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      r_next = r_reg;
      // Shift histories; a level is taken only when all samples agree
      r_next.sclSh = {r_reg.sclSh[FiltLen-2:0], pins.sclIn};
      r_next.sdaSh = {r_reg.sdaSh[FiltLen-2:0], pins.sdaIn};
      sclNew = r_reg.sclF;
      sdaNew = r_reg.sdaF;
      if (&r_reg.sclSh) begin
         sclNew = 1'b1;
      end else if (~|r_reg.sclSh) begin
         sclNew = 1'b0;
      end
      if (&r_reg.sdaSh) begin
         sdaNew = 1'b1;
      end else if (~|r_reg.sdaSh) begin
         sdaNew = 1'b0;
      end
      r_next.sclF = sclNew;
      r_next.sdaF = sdaNew;
      sclRise   = !r_reg.sclF && sclNew;
      sclFall   = r_reg.sclF && !sclNew;
      // Start also serves as repeated start
      startCond = r_reg.sclF && sclNew && r_reg.sdaF && !sdaNew;
      stopCond  = r_reg.sclF && sclNew && !r_reg.sdaF && sdaNew;
      rxPush = 1'b0;
      txPop  = 1'b0;
      // Core side handshakes
      rxPop  = rxByte.valid && rxReady;
      txPush = txByte.valid && txReady;

      // Reset pin held low keeps state, drive and FIFOs cleared
      r_next.inRst = !externalResetLow;
      if (r_reg.inRst && externalResetLow) begin
         // Release: capture straps, then run
         r_next.boot  = !hostAttentionLine;
         r_next.fault = !motionIrqBootStrap && !motionSelectBootStrap;
      end

      unique case (r_reg.st)
         hbp_pkg::ST_IDLE: begin
            r_next.drvLow = 1'b0;
         end
         hbp_pkg::ST_ADDR, hbp_pkg::ST_WRX: begin
            if (sclRise) begin
               r_next.shift  = {r_reg.shift[6:0], r_reg.sdaF};
               r_next.bitCnt = r_reg.bitCnt + 4'h1;
            end
            if (sclFall && r_reg.bitCnt == 4'h8) begin
               r_next.bitCnt = 4'h0;
               if (r_reg.st == hbp_pkg::ST_ADDR) begin
                  if (r_reg.shift[7:1] == TargetAddr) begin
                     r_next.rd     = r_reg.shift[0];
                     r_next.drvLow = 1'b1;
                     r_next.st     = hbp_pkg::ST_AACK;
                  end else begin
                     // Foreign address: stay off the bus until next start
                     r_next.st = hbp_pkg::ST_IDLE;
                  end
               end else begin
                  // Full receive FIFO answers with not-acknowledge unless the core pops a byte in the same cycle
                  r_next.nack   = (r_reg.rxCnt == 4'(Depth)) && !rxPop;
                  r_next.drvLow = !r_next.nack;
                  rxPush        = !r_next.nack;
                  r_next.st     = hbp_pkg::ST_WACK;
               end
            end
         end
         hbp_pkg::ST_AACK, hbp_pkg::ST_WACK: begin
            if (sclFall) begin
               if (r_reg.rd && r_reg.st == hbp_pkg::ST_AACK) begin
                  // Empty transmit FIFO sends all ones
                  r_next.shift  = (r_reg.txCnt != 4'h0) ? r_reg.txMem[r_reg.txRp] : 8'hFF;
                  txPop         = (r_reg.txCnt != 4'h0);
                  r_next.drvLow = !r_next.shift[7];
                  r_next.bitCnt = 4'h0;
                  r_next.st     = hbp_pkg::ST_RTX;
               end else begin
                  r_next.drvLow = 1'b0;
                  r_next.st     = r_reg.nack ? hbp_pkg::ST_IDLE : hbp_pkg::ST_WRX;
               end
            end
         end
         hbp_pkg::ST_RTX: begin
            if (sclFall) begin
               r_next.bitCnt = r_reg.bitCnt + 4'h1;
               if (r_reg.bitCnt == 4'h7) begin
                  r_next.drvLow = 1'b0;
                  r_next.st     = hbp_pkg::ST_RACK;
               end else begin
                  r_next.shift  = {r_reg.shift[6:0], 1'b1};
                  r_next.drvLow = !r_reg.shift[6];
               end
            end
         end
         hbp_pkg::ST_RACK: begin
            if (sclRise) begin
               // Controller not-acknowledge ends the read
               r_next.nack = r_reg.sdaF;
            end
            if (sclFall) begin
               if (r_reg.nack) begin
                  r_next.st = hbp_pkg::ST_IDLE;
               end else begin
                  r_next.shift  = (r_reg.txCnt != 4'h0) ? r_reg.txMem[r_reg.txRp] : 8'hFF;
                  txPop         = (r_reg.txCnt != 4'h0);
                  r_next.drvLow = !r_next.shift[7];
                  r_next.bitCnt = 4'h0;
                  r_next.st     = hbp_pkg::ST_RTX;
               end
            end
         end
         default: begin
            r_next.st = hbp_pkg::ST_IDLE;
         end
      endcase

      // Start and stop override any byte in flight
      if (startCond) begin
         r_next.st     = hbp_pkg::ST_ADDR;
         r_next.bitCnt = 4'h0;
         r_next.drvLow = 1'b0;
         r_next.nack   = 1'b0;
      end else if (stopCond) begin
         r_next.st     = hbp_pkg::ST_IDLE;
         r_next.drvLow = 1'b0;
      end

      // Receive FIFO bookkeeping
      if (rxPush) begin
         r_next.rxMem[r_reg.rxWp] = r_reg.shift;
         r_next.rxWp = r_reg.rxWp + 3'h1;
      end
      if (rxPop) begin
         r_next.rxRp = r_reg.rxRp + 3'h1;
      end
      r_next.rxCnt = r_reg.rxCnt + {3'h0, rxPush} - {3'h0, rxPop};

      // Transmit FIFO bookkeeping
      if (txPush) begin
         r_next.txMem[r_reg.txWp] = txByte.data;
         r_next.txWp = r_reg.txWp + 3'h1;
      end
      if (txPop) begin
         r_next.txRp = r_reg.txRp + 3'h1;
      end
      r_next.txCnt = r_reg.txCnt + {3'h0, txPush} - {3'h0, txPop};
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         r_reg       <= '0;
         r_reg.inRst <= 1'b1;
         r_reg.sclSh <= '1;       // Idle bus reads high
         r_reg.sdaSh <= '1;
         r_reg.sclF  <= 1'b1;
         r_reg.sdaF  <= 1'b1;
         r_reg.st    <= hbp_pkg::ST_IDLE;
         r_reg.rxCnt <= hbp_pkg::FIFO_CNT_RESET;
         r_reg.txCnt <= hbp_pkg::FIFO_CNT_RESET;
      end else if (r_reg.inRst) begin
         // State, data drive and FIFO pointers and counts wiped while the pin holds reset
         r_reg       <= r_next;
         r_reg.st    <= hbp_pkg::ST_IDLE;
         r_reg.drvLow <= 1'b0;
         r_reg.rxCnt <= '0;
         r_reg.rxWp  <= '0;
         r_reg.rxRp  <= '0;
         r_reg.txCnt <= '0;
         r_reg.txWp  <= '0;
         r_reg.txRp  <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign sdaOe         = r_reg.drvLow;  // Released unless addressed
   assign sdaOut        = 1'b0;
   assign sclOe         = 1'b0;
   assign sclOut        = 1'b0;
   assign coreRun       = !r_reg.inRst;
   assign bootMode      = r_reg.boot;
   assign strapFault    = r_reg.fault;
   assign hostWantsTalk = coreRun && !hostAttentionLine;
   assign rxByte.valid  = coreRun && (r_reg.rxCnt != 4'h0);
   assign rxByte.data   = r_reg.rxMem[r_reg.rxRp];
   assign txReady       = coreRun && (r_reg.txCnt != 4'(Depth));
endmodule // hbp_host_port

// ### design/hbp_pkg.sv
// Package for the hub host port: constants, states and carrier structs
package hbp_pkg;
   // ----------------------------------------
   // Bus constants
   // ----------------------------------------
   localparam logic [6:0] TARGET_ADDR    = 7'h55;  // Fixed 7-bit target address
   localparam int         FIFO_DEPTH     = 8;      // Bytes in each direction
   localparam int         CLK_HZ         = 50_000_000;
   localparam int         SPIKE_NS       = 75;     // Widest spike rejected
   localparam int         CLK_NS         = 20;
   // Longest time rounds down, at least one cycle
   localparam int         SPIKE_CYC      = (SPIKE_NS / CLK_NS) < 1 ? 1 : (SPIKE_NS / CLK_NS);
   localparam int         FILT_LEN       = SPIKE_CYC + 1; // Samples that must agree
   localparam logic [3:0] FIFO_CNT_RESET = 4'h0;

   // ----------------------------------------
   // Protocol states, one-hot
   // ----------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b000_0001,  // Waiting for start
      ST_ADDR  = 7'b000_0010,  // Shifting address byte
      ST_AACK  = 7'b000_0100,  // Driving address acknowledge
      ST_WRX   = 7'b000_1000,  // Receiving write data
      ST_WACK  = 7'b001_0000,  // Driving data acknowledge
      ST_RTX   = 7'b010_0000,  // Sending read data
      ST_RACK  = 7'b100_0000   // Sampling controller acknowledge
   } hbp_state_type;

   // Pin bundle for the open-drain clock and data lines
   typedef struct packed {
      logic sclIn;
      logic sdaIn;
   } hbp_pins_type;

   // Byte stream with handshake
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } hbp_byte_type;
endpackage : hbp_pkg

// ### tb/hbp_host_port_asserts.sv
// Checker for reset, boot capture, bus and byte stream behaviour of the host port
`timescale 1ns/1ps
module hbp_host_port_asserts #(
   parameter int FiltLen = hbp_pkg::FILT_LEN
) (
   input wire logic                  clk_sys,
   input wire logic                  sys_rst,
   input wire logic                  externalResetLow,
   input wire logic                  motionIrqBootStrap,
   input wire logic                  motionSelectBootStrap,
   input wire logic                  hostAttentionLine,
   input wire hbp_pkg::hbp_pins_type pins,
   input wire logic                  sdaOe,
   input wire logic                  sdaOut,
   input wire logic                  sclOe,
   input wire logic                  sclOut,
   input wire logic                  coreRun,
   input wire logic                  bootMode,
   input wire logic                  strapFault,
   input wire logic                  hostWantsTalk,
   input wire hbp_pkg::hbp_byte_type rxByte,
   input wire logic                  rxReady,
   input wire hbp_pkg::hbp_byte_type txByte,
   input wire logic                  txReady
);
   // ----------------------------------------
   // Properties, all in the system clock domain
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_hold; !externalResetLow |=> !coreRun; endproperty
   a_hold: assert property (p_hold) else $error("core ran in reset");
   property p_clear; !externalResetLow ##1 !externalResetLow |-> !sdaOe && !rxByte.valid && !txReady; endproperty
   a_clear: assert property (p_clear) else $error("port active in reset");
   property p_run; $rose(externalResetLow) |=> coreRun [*2]; endproperty
   a_run: assert property (p_run) else $error("no start after release");
   property p_boot; $rose(externalResetLow) |=> bootMode == !$past(hostAttentionLine); endproperty
   a_boot: assert property (p_boot) else $error("boot choice wrong");
   property p_edge; $changed(sdaOe) && $past(externalResetLow) |-> !pins.sclIn; endproperty
   a_edge: assert property (p_edge) else $error("data moved with clock high");
   property p_drain; sdaOe |-> !sdaOut && !sclOe; endproperty
   a_drain: assert property (p_drain) else $error("line driven high");
   property p_filt; $rose(sdaOe) |-> !$past(pins.sclIn) && !$past(pins.sclIn, FiltLen); endproperty
   a_filt: assert property (p_filt) else $error("drive before filtered fall");
   property p_rxhold; rxByte.valid && !rxReady && externalResetLow |=> rxByte.valid && $stable(rxByte.data); endproperty
   a_rxhold: assert property (p_rxhold) else $error("rx byte lost");
   property p_txrun; txReady |-> coreRun; endproperty
   a_txrun: assert property (p_txrun) else $error("tx ready in reset");
endmodule // hbp_host_port_asserts

bind hbp_host_port hbp_host_port_asserts #(.FiltLen(FiltLen)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .externalResetLow(externalResetLow), .motionIrqBootStrap(motionIrqBootStrap), .pins(pins),
   .motionSelectBootStrap(motionSelectBootStrap), .hostAttentionLine(hostAttentionLine), .sdaOe(sdaOe),
   .sdaOut(sdaOut), .sclOe(sclOe), .sclOut(sclOut), .coreRun(coreRun), .bootMode(bootMode), .rxByte(rxByte),
   .strapFault(strapFault), .hostWantsTalk(hostWantsTalk), .rxReady(rxReady), .txByte(txByte), .txReady(txReady));

// ### tb/hbp_host_model.sv
// Host controller model driving the open-drain clock and data lines
`timescale 1ns/1ps
module hbp_host_model #(
   parameter int Quarter = 33 // Bit is 132 cycles, under 400kHz
) (
   input wire logic clk_sys,
   input wire logic sdaLine, // Resolved data level
   output logic     sclLow,  // High pulls clock low
   output logic     sdaLow   // High pulls data low
);
   // ----------------------------------------
   // Bus phases, changed just after a falling edge
   // ----------------------------------------
   initial begin
      sclLow = 1'b0;
      sdaLow = 1'b0;
   end
   task automatic wq();
      repeat (Quarter) @(negedge clk_sys);
   endtask
   // Start or repeated start, data falls with clock high
   task automatic start();
      sdaLow = 1'b0; wq(); sclLow = 1'b0; wq(); sdaLow = 1'b1; wq(); sclLow = 1'b1; wq();
   endtask
   task automatic stop();
      sdaLow = 1'b1; wq(); sclLow = 1'b0; wq(); sdaLow = 1'b0; wq();
   endtask
   // One bit; glitch drops clock 60ns, shorter than the filter span
   task automatic bit_io(input logic b, input logic glitch, output logic r);
      sdaLow = !b; wq(); sclLow = 1'b0; wq();
      r = sdaLine;
      if (glitch) begin
         sclLow = 1'b1; repeat (3) @(negedge clk_sys); sclLow = 1'b0;
      end
      wq(); sclLow = 1'b1; wq();
   endtask
   // Byte MSB first, then the ninth bit; ackOut is low seen there
   task automatic byte_io(input logic [7:0] d, input logic ackIn, input logic glitch,
                          output logic [7:0] q, output logic ackOut);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], glitch && i == 3, q[i]);
      bit_io(ackIn, 1'b0, r);
      ackOut = !r;
   endtask
endmodule // hbp_host_model

// ### tb/tb_top.sv
// Testbench for the hub host port
`timescale 1ns/1ps
module tb_top;
   logic clk_sys, sys_rst, externalResetLow, motionIrqBootStrap, motionSelectBootStrap, hostAttentionLine;
   logic sdaOe, sdaOut, sclOe, sclOut, coreRun, bootMode, strapFault, hostWantsTalk, rxReady, txReady;
   logic sclLow, sdaLow, sdaLine, a;
   logic [7:0] q;
   hbp_pkg::hbp_pins_type pins;
   hbp_pkg::hbp_byte_type rxByte, txByte;
   int n_mismatch = 0, check_count = 0, cycles = 0;
   // Pull-ups win unless someone pulls low
   assign sdaLine = !(sdaLow || (sdaOe && !sdaOut));
   assign pins = {!(sclLow || (sclOe && !sclOut)), sdaLine};
   hbp_host_port i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .externalResetLow(externalResetLow),
      .motionIrqBootStrap(motionIrqBootStrap), .motionSelectBootStrap(motionSelectBootStrap), .pins(pins),
      .hostAttentionLine(hostAttentionLine), .sdaOe(sdaOe), .sdaOut(sdaOut), .sclOe(sclOe), .sclOut(sclOut),
      .coreRun(coreRun), .bootMode(bootMode), .strapFault(strapFault), .hostWantsTalk(hostWantsTalk),
      .rxByte(rxByte), .rxReady(rxReady), .txByte(txByte), .txReady(txReady));
   hbp_host_model i_host (.clk_sys(clk_sys), .sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Hang guard, runs need about 33000 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_mismatch++;
         finish_test();
      end
   end
   // Reset pin pulses with every strap mix, attention following the select strap
   task automatic t_boot();
      for (int i = 0; i < 4; i++) begin
         externalResetLow = 1'b0;
         hostAttentionLine = i[0];
         {motionIrqBootStrap, motionSelectBootStrap} = {i[1], i[0]};
         repeat (3) @(negedge clk_sys);
         chk({7'h0, coreRun}, 8'h00);
         externalResetLow = 1'b1;
         repeat (2) @(negedge clk_sys);
         chk({5'h0, coreRun, bootMode, strapFault}, {5'h0, 1'b1, !i[0], !(i[0] | i[1])});
      end
   endtask
   // Glitched address, fill receive side until refused, then drain
   task automatic t_write();
      hostAttentionLine = 1'b0;
      @(negedge clk_sys);
      chk({7'h0, hostWantsTalk}, 8'h01);
      i_host.start();
      i_host.byte_io({7'h55, 1'b0}, 1'b1, 1'b1, q, a);
      chk({7'h0, a}, 8'h01);
      for (int i = 0; i < 9; i++) begin
         i_host.byte_io(8'hC0 + 8'(i), 1'b1, 1'b0, q, a);
         chk({7'h0, a}, {7'h0, i < 8});
      end
      i_host.stop();
      rxReady = 1'b1;
      for (int i = 0; i < 8; i++) begin
         chk({rxByte.valid, 7'h0}, 8'h80);
         chk(rxByte.data, 8'hC0 + 8'(i));
         @(negedge clk_sys);
      end
      rxReady = 1'b0;
      chk({7'h0, rxByte.valid}, 8'h00);
   endtask
   // Foreign address is left alone
   task automatic t_foreign();
      i_host.start();
      i_host.byte_io({7'h54, 1'b0}, 1'b1, 1'b0, q, a);
      chk({7'h0, a}, 8'h00);
      i_host.byte_io(8'h00, 1'b1, 1'b0, q, a);
      chk({7'h0, a}, 8'h00);
      i_host.stop();
      chk({7'h0, rxByte.valid}, 8'h00);
   endtask
   // Fill transmit side, write then repeated start and read past empty
   task automatic t_read();
      for (int i = 0; i < 8; i++) begin
         txByte = {1'b1, 8'h30 + 8'(i)};
         @(negedge clk_sys);
      end
      txByte.valid = 1'b0;
      chk({7'h0, txReady}, 8'h00);
      i_host.start();
      i_host.byte_io({7'h55, 1'b0}, 1'b1, 1'b0, q, a);
      i_host.byte_io(8'hA5, 1'b1, 1'b0, q, a);
      chk({7'h0, a}, 8'h01);
      i_host.start();
      i_host.byte_io({7'h55, 1'b1}, 1'b1, 1'b0, q, a);
      chk({7'h0, a}, 8'h01);
      for (int i = 0; i < 9; i++) begin
         i_host.byte_io(8'hFF, i == 8, 1'b0, q, a);
         chk(q, i < 8 ? 8'h30 + 8'(i) : 8'hFF);
      end
      i_host.stop();
      chk(rxByte.data, 8'hA5);
   endtask
   // Reset pulse with attention held low, then an image is written in
   task automatic t_image();
      externalResetLow = 1'b0;
      {motionIrqBootStrap, motionSelectBootStrap} = 2'b11;
      repeat (3) @(negedge clk_sys);
      externalResetLow = 1'b1;
      // Let the filter settle before the first start
      repeat (10) @(negedge clk_sys);
      chk({4'h0, coreRun, bootMode, strapFault, rxByte.valid}, 8'h0C);
      chk({5'h0, sdaOut, sclOe, sclOut}, 8'h00);
      i_host.start();
      i_host.byte_io({7'h55, 1'b0}, 1'b1, 1'b0, q, a);
      chk({7'h0, a}, 8'h01);
      // Pin map command first, then a byte of the keyed image
      i_host.byte_io(8'h00, 1'b1, 1'b0, q, a);
      chk({7'h0, a}, 8'h01);
      i_host.byte_io(8'hC3, 1'b1, 1'b0, q, a);
      chk({7'h0, a}, 8'h01);
      i_host.stop();
      rxReady = 1'b1;
      chk(rxByte.data, 8'h00);
      @(negedge clk_sys);
      chk(rxByte.data, 8'hC3);
      @(negedge clk_sys);
      rxReady = 1'b0;
      chk({7'h0, rxByte.valid}, 8'h00);
   endtask
   initial begin
      sys_rst = 1'b1;
      externalResetLow = 1'b0;
      {motionIrqBootStrap, motionSelectBootStrap} = 2'b11;
      hostAttentionLine = 1'b1;
      rxReady = 1'b0;
      txByte = '0;
      repeat (6) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_boot();
      repeat (10) @(negedge clk_sys);
      t_write();
      t_foreign();
      t_read();
      t_image();
      finish_test();
   end
endmodule // tb_top
